// ### src/mts_march.sv
// March test sequencer for a 1024 x 1 dynamic RAM
//
// Behaviour
// - Memory holds 1024 one-bit cells, 32 rows of 32; test covers 0..1023.
// - Five low address bits select the row; tester drives row there.
// - Each access rewrites the whole selected row, so visiting a row refreshes it.
// - Five high address bits select the column amplifier to data pins.
`timescale 1ns/10ps
`default_nettype none
module mts_march #(
   parameter int REF_CYCLES = mts_pkg::REF_CYC
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic start,
   input wire logic background,
   input wire logic ram_data_in,
   output logic [4:0] ram_row,
   output logic [4:0] ram_col,
   output logic ram_precharge,
   output logic ram_chip_enable,
   output logic ram_write,
   output logic ram_data_out,
   output logic busy,
   output logic done,
   output logic fail,
   output logic [9:0] fail_addr
);
   localparam logic [16:0] REF_DUE_AT = (REF_CYCLES > mts_pkg::REF_MARGIN) ?
      17'(REF_CYCLES - mts_pkg::REF_MARGIN) : 17'h00001;
   localparam logic [16:0] REF_MAX = 17'(REF_CYCLES);
   logic rst_meta;
   logic rst_sync_n;
   logic start_sync;
   logic bg_sync;
   logic data_sync;
   mts_pkg::mts_state_t state, next_state;
   mts_pkg::mts_phase_t phase, next_phase;
   logic [9:0] addr, next_addr;
   logic is_write, next_is_write;
   logic [3:0] cnt, next_cnt;
   logic refresh_mode, next_refresh_mode;
   logic [4:0] ref_row, next_ref_row;
   logic [16:0] ref_count, next_ref_count;
   logic bg, next_bg;
   logic start_prev;
   logic start_edge;
   logic expect_bit;
   logic row_wrap;
   logic finished;
   logic [4:0] next_ram_row;
   logic [4:0] next_ram_col;
   logic next_ram_precharge;
   logic next_ram_chip_enable;
   logic next_ram_write;
   logic next_ram_data_out;
   logic next_busy;
   logic next_done;
   logic next_fail;
   logic [9:0] next_fail_addr;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end
   mts_sync3 u_sync_start (
      .clock(clock),
      .rst_n(rst_sync_n),
      .din(start),
      .q(start_sync)
   );
   mts_sync3 u_sync_bg (
      .clock(clock),
      .rst_n(rst_sync_n),
      .din(background),
      .q(bg_sync)
   );
   mts_sync3 u_sync_data (
      .clock(clock),
      .rst_n(rst_sync_n),
      .din(ram_data_in),
      .q(data_sync)
   );
   assign start_edge = start_sync & ~start_prev;
   always_comb begin
      next_state = state;
      next_phase = phase;
      next_addr = addr;
      next_is_write = is_write;
      next_cnt = (cnt == 4'h0) ? cnt : cnt - 4'h1;
      next_refresh_mode = refresh_mode;
      next_ref_row = ref_row;
      next_ref_count = (ref_count == REF_MAX) ? ref_count :
         ref_count + 17'h00001;
      next_bg = bg;
      next_done = done;
      next_fail = fail;
      next_fail_addr = fail_addr;
      finished = 1'b0;
      expect_bit = (phase == mts_pkg::MTS_UP) ? bg : ~bg;
      row_wrap = (phase == mts_pkg::MTS_DOWN) ?
         (addr[4:0] == mts_pkg::FIRST_ROW) : (addr[4:0] == mts_pkg::LAST_ROW);
      unique case (state)
         mts_pkg::MTS_IDLE: begin
            next_ref_count = 17'h00000;
            if (start_edge) begin
               next_bg = bg_sync;
               next_phase = mts_pkg::MTS_FILL;
               next_addr = mts_pkg::FIRST_ADDR;
               next_is_write = 1'b1;
               next_refresh_mode = 1'b0;
               next_fail = 1'b0;
               next_fail_addr = 10'h000;
               next_done = 1'b0;
               next_cnt = mts_pkg::PC_LOAD;
               next_state = mts_pkg::MTS_PRE;
            end
         end
         mts_pkg::MTS_PRE: begin
            if (cnt == 4'h0) begin
               next_cnt = (is_write && !refresh_mode) ?
                  mts_pkg::WP_LOAD : mts_pkg::RD_LOAD;
               next_state = mts_pkg::MTS_CE;
            end
         end
         mts_pkg::MTS_CE: begin
            if (cnt == 4'h0) begin
               if (!is_write && !refresh_mode && data_sync != expect_bit) begin
                  next_fail = 1'b1;
                  next_fail_addr = addr;
               end
               next_cnt = mts_pkg::CP_LOAD;
               next_state = mts_pkg::MTS_GAP;
            end
         end
         mts_pkg::MTS_GAP: begin
            if (cnt == 4'h0) begin
               next_cnt = mts_pkg::PC_LOAD;
               next_state = mts_pkg::MTS_PRE;
               if (refresh_mode) begin
                  if (ref_row == mts_pkg::LAST_ROW) begin
                     next_refresh_mode = 1'b0;
                     next_ref_count = 17'h00000;
                  end else begin
                     next_ref_row = ref_row + 5'h01;
                  end
               end else begin
                  if (is_write && row_wrap) begin
                     next_ref_count = 17'h00000;
                  end
                  unique case (phase)
                     mts_pkg::MTS_FILL: begin
                        if (addr == mts_pkg::LAST_ADDR) begin
                           next_phase = mts_pkg::MTS_UP;
                           next_addr = mts_pkg::FIRST_ADDR;
                           next_is_write = 1'b0;
                        end else begin
                           next_addr = addr + 10'h001;
                        end
                     end
                     mts_pkg::MTS_UP: begin
                        if (!is_write) begin
                           next_is_write = 1'b1;
                        end else if (addr == mts_pkg::LAST_ADDR) begin
                           next_phase = mts_pkg::MTS_DOWN;
                           next_is_write = 1'b0;
                        end else begin
                           next_addr = addr + 10'h001;
                           next_is_write = 1'b0;
                        end
                     end
                     default: begin
                        if (!is_write) begin
                           next_is_write = 1'b1;
                        end else if (addr == mts_pkg::FIRST_ADDR) begin
                           finished = 1'b1;
                        end else begin
                           next_addr = addr - 10'h001;
                           next_is_write = 1'b0;
                        end
                     end
                  endcase
                  if (finished) begin
                     next_done = 1'b1;
                     next_state = mts_pkg::MTS_IDLE;
                  end else if (ref_count >= REF_DUE_AT) begin
                     next_refresh_mode = 1'b1;
                     next_ref_row = mts_pkg::FIRST_ROW;
                  end
               end
            end
         end
      endcase
      next_ram_precharge = (next_state == mts_pkg::MTS_PRE);
      next_ram_chip_enable = (next_state == mts_pkg::MTS_CE);
      next_ram_write = (next_state == mts_pkg::MTS_CE) && next_is_write &&
         !next_refresh_mode;
      next_ram_row = next_refresh_mode ? next_ref_row : next_addr[4:0];
      next_ram_col = next_addr[9:5];
      next_ram_data_out = (next_phase == mts_pkg::MTS_UP) ? ~next_bg : next_bg;
      next_busy = (next_state != mts_pkg::MTS_IDLE);
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state <= mts_pkg::MTS_IDLE;
         phase <= mts_pkg::MTS_FILL;
         addr <= 10'h000;
         is_write <= 1'b0;
         cnt <= 4'h0;
         refresh_mode <= 1'b0;
         ref_row <= 5'h00;
         ref_count <= 17'h00000;
         bg <= 1'b0;
         start_prev <= 1'b0;
         ram_row <= 5'h00;
         ram_col <= 5'h00;
         ram_precharge <= 1'b0;
         ram_chip_enable <= 1'b0;
         ram_write <= 1'b0;
         ram_data_out <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
         fail <= 1'b0;
         fail_addr <= 10'h000;
      end else begin
         state <= next_state;
         phase <= next_phase;
         addr <= next_addr;
         is_write <= next_is_write;
         cnt <= next_cnt;
         refresh_mode <= next_refresh_mode;
         ref_row <= next_ref_row;
         ref_count <= next_ref_count;
         bg <= next_bg;
         start_prev <= start_sync;
         ram_row <= next_ram_row;
         ram_col <= next_ram_col;
         ram_precharge <= next_ram_precharge;
         ram_chip_enable <= next_ram_chip_enable;
         ram_write <= next_ram_write;
         ram_data_out <= next_ram_data_out;
         busy <= next_busy;
         done <= next_done;
         fail <= next_fail;
         fail_addr <= next_fail_addr;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_sync_n);
   sequence s_precharge;
      ram_precharge [*4];
   endsequence
   sequence s_enable;
      !ram_precharge && ram_chip_enable;
   endsequence
   a_pre_then_ce: assert property (
      $rose(ram_precharge) |-> s_precharge ##1 s_enable)
      else $error("precharge not followed by chip enable");
   a_write_in_ce: assert property (
      ram_write |-> ram_chip_enable && !ram_precharge)
      else $error("write clock outside chip enable");
   a_fill_data: assert property (
      ram_chip_enable && phase == mts_pkg::MTS_FILL && !refresh_mode
      |-> ram_write && ram_data_out == bg)
      else $error("fill phase not writing background");
   a_up_complement: assert property (
      ram_write && phase == mts_pkg::MTS_UP |-> ram_data_out == !bg)
      else $error("up phase not writing complement");
   a_down_restore: assert property (
      ram_write && phase == mts_pkg::MTS_DOWN |-> ram_data_out == bg)
      else $error("down phase not restoring background");
   a_addr_on_pins: assert property (
      ram_chip_enable && !refresh_mode |-> {ram_col, ram_row} == addr)
      else $error("address pins do not match location");
   a_ref_bound: assert property (
      ref_count < REF_MAX)
      else $error("row refresh interval exceeded");
   a_fail_sticky: assert property (
      fail && !start_edge |=> fail)
      else $error("fail flag dropped");
   a_done_at_end: assert property (
      $rose(done) |-> phase == mts_pkg::MTS_DOWN && addr == 10'h000 && !busy)
      else $error("done raised before end of third phase");
endmodule : mts_march
`default_nettype wire

// ### src/mts_pkg.sv
// Constants and types for the march test sequencer
package mts_pkg;
   localparam int CLK_PERIOD_NS = 40;
   localparam int ADDR_W = 10;
   localparam int ROW_W = 5;
   localparam int CNT_W = 4;
   localparam int REF_W = 17;
   localparam logic [9:0] FIRST_ADDR = 10'h000;
   localparam logic [9:0] LAST_ADDR = 10'h3FF;
   localparam logic [4:0] FIRST_ROW = 5'h00;
   localparam logic [4:0] LAST_ROW = 5'h1F;
   // Access timing in ns, refresh period in ms, synchroniser latency in cycles
   localparam int T_PC_NS = 125;
   localparam int T_ACC_NS = 300;
   localparam int T_WP_NS = 50;
   localparam int T_CP_NS = 85;
   localparam int T_REF_MS = 2;
   localparam int SYNC_LAT = 4;
   // Least times round up
   localparam int PC_CYC = (T_PC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CP_CYC = (T_CP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] PC_LOAD = 4'(PC_CYC - 1);
   localparam logic [3:0] RD_LOAD = 4'(ACC_CYC + SYNC_LAT - 1);
   localparam logic [3:0] WP_LOAD = 4'(WP_CYC - 1);
   localparam logic [3:0] CP_LOAD = 4'(CP_CYC - 1);
   // Longest time rounds down
   localparam int REF_CYC = (T_REF_MS * 1000000) / CLK_PERIOD_NS;
   localparam int REF_MARGIN = 1024;
   typedef enum logic [1:0] {
      MTS_IDLE = 2'b00,
      MTS_PRE = 2'b01,
      MTS_CE = 2'b10,
      MTS_GAP = 2'b11
   } mts_state_t;
   typedef enum logic [1:0] {
      MTS_FILL = 2'b00,
      MTS_UP = 2'b01,
      MTS_DOWN = 2'b10
   } mts_phase_t;
endpackage : mts_pkg

// ### src/mts_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module mts_sync3 (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic din,
   output logic q
);
   logic s1;
   logic s2;
   logic s3;
   logic next_q;

   always_comb begin
      next_q = (s2 == s3) ? s3 : q;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         q <= 1'b0;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         q <= next_q;
      end
   end
endmodule : mts_sync3
`default_nettype wire

// ### tb/mts_ram_model.sv
// Behavioural 1024 x 1 dynamic RAM seen by the march sequencer
`timescale 1ns/10ps
`default_nettype none
module mts_ram_model (
   input wire logic [4:0] row,
   input wire logic [4:0] col,
   input wire logic precharge,
   input wire logic chip_enable,
   input wire logic write_clk,
   input wire logic data_in,
   input wire logic stuck_en,
   input wire logic [9:0] stuck_addr,
   input wire logic stuck_val,
   output logic data_out
);
   logic cells [0:1023];
   realtime last_ref [0:31];
   realtime t_pre;
   int proto_errs = 0;
   int ref_errs = 0;
   logic pre_seen = 1'b0;
   logic [9:0] addr;
   logic val;
   initial begin
      data_out = 1'b0;
      t_pre = 0.0;
      for (int i = 0; i < 32; i++) last_ref[i] = 0.0;
   end
   always @(posedge precharge) begin
      pre_seen = 1'b1;
      t_pre = $realtime;
   end
   always @(posedge chip_enable) begin
      #1;
      addr = {col, row};
      if (!pre_seen) proto_errs++;
      pre_seen = 1'b0;
      if ($realtime - last_ref[row] > 2.0e6) ref_errs++;
      last_ref[row] = $realtime;
      if (write_clk) begin
         cells[addr] = data_in;
      end else begin
         val = (stuck_en && addr == stuck_addr) ? stuck_val : cells[addr];
         data_out = ~val;
         #(mts_pkg::T_ACC_NS - ($realtime - t_pre));
         // A reset may cut the access short; never wait on a later access
         if (chip_enable) begin
            data_out = val;
            @(negedge chip_enable);
         end
         #1;
         data_out = ~val;
      end
   end
endmodule : mts_ram_model
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the march test sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic start = 1'b0;
   logic background = 1'b0;
   logic ram_data_in;
   logic [4:0] ram_row, ram_col;
   logic ram_precharge, ram_chip_enable, ram_write, ram_data_out;
   logic busy, done, fail;
   logic [9:0] fail_addr;
   logic stuck_en = 1'b0;
   logic [9:0] stuck_addr = 10'h000;
   logic stuck_val = 1'b0;
   logic seq_on = 1'b0;
   logic prev_ce = 1'b0;
   logic bg_q = 1'b0;
   int n_errors = 0;
   int samples_checked = 0;
   int k = 0;
   always #20 clock = ~clock;
   mts_march uut (.clock(clock), .reset_n(reset_n), .start(start),
      .background(background), .ram_data_in(ram_data_in),
      .ram_row(ram_row), .ram_col(ram_col), .ram_precharge(ram_precharge),
      .ram_chip_enable(ram_chip_enable), .ram_write(ram_write),
      .ram_data_out(ram_data_out), .busy(busy), .done(done), .fail(fail),
      .fail_addr(fail_addr));
   mts_ram_model ram (.row(ram_row), .col(ram_col), .precharge(ram_precharge),
      .chip_enable(ram_chip_enable), .write_clk(ram_write),
      .data_in(ram_data_out), .stuck_en(stuck_en), .stuck_addr(stuck_addr),
      .stuck_val(stuck_val), .data_out(ram_data_in));
   task automatic complete_run();
      $display("checked=%0d mismatches=%0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run
   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_val
   task automatic wait_high(input bit sel_done, input int limit);
      int n;
      n = 0;
      while ((sel_done ? done : busy) !== 1'b1) begin
         @(negedge clock);
         n++;
         if (n >= limit) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, n, limit);
            complete_run();
         end
      end
   endtask : wait_high
   // Expected {write, data, address} of access number i
   function automatic logic [11:0] exp_op(input int i, input logic b);
      int j;
      j = (i < 3072) ? (i - 1024) / 2 : (i - 3072) / 2;
      if (i < 1024) return {1'b1, b, 10'(i)};
      if (i < 3072) return {i[0], i[0] & ~b, 10'(j)};
      return {i[0], i[0] & b, 10'(1023 - j)};
   endfunction : exp_op
   // Access monitor on the RAM pins
   always @(negedge clock) begin
      if (!reset_n) begin
         k = 0;
      end else if (ram_chip_enable && !prev_ce && seq_on) begin
         check_val(
            16'({ram_write, ram_write & ram_data_out, ram_col, ram_row}),
            16'(exp_op(k, bg_q)));
         k++;
      end
      prev_ce = ram_chip_enable;
   end
   initial begin
      int cyc;
      int bad;
      cyc = $urandom(32'h39A59AD2);
      repeat (6) @(negedge clock);
      reset_n = 1'b1;
      repeat (4) @(negedge clock);
      background = 1'($urandom);
      start = 1'b1;
      wait_high(1'b0, 20);
      cyc = 50 + $urandom % 400;
      repeat (cyc) @(negedge clock);
      reset_n = 1'b0;
      start = 1'b0;
      @(negedge clock);
      check_val(
         16'({busy, done, fail, ram_precharge, ram_chip_enable}), 16'h0000);
      repeat (2) @(negedge clock);
      reset_n = 1'b1;
      @(negedge clock);
      check_val(16'({busy, done, fail, ram_chip_enable}), 16'h0000);
      $display("test reset_abort ended");
      repeat (4) @(negedge clock);
      background = 1'($urandom);
      bg_q = background;
      stuck_addr = 10'($urandom);
      stuck_val = ~background;
      stuck_en = 1'b1;
      seq_on = 1'b1;
      start = 1'b1;
      wait_high(1'b0, 20);
      start = 1'b0;
      repeat (3000) @(negedge clock);
      start = 1'b1;
      repeat (10) @(negedge clock);
      start = 1'b0;
      wait_high(1'b1, 80000);
      check_val(16'({busy, fail}), 16'h0001);
      check_val(16'(fail_addr), 16'(stuck_addr));
      check_val(16'(k), 16'h1400);
      check_val(16'(ram.proto_errs), 16'h0000);
      check_val(16'(ram.ref_errs), 16'h0000);
      bad = 0;
      for (int i = 0; i < 1024; i++) begin
         if (ram.cells[i] !== bg_q) bad++;
      end
      check_val(16'(bad), 16'h0000);
      $display("test full_march ended");
      seq_on = 1'b0;
      repeat (8) @(negedge clock);
      check_val(16'({done, busy, fail}), 16'h0005);
      start = 1'b1;
      wait_high(1'b0, 20);
      check_val(16'({done, fail}), 16'h0000);
      check_val(16'(fail_addr), 16'h0000);
      $display("test restart ended");
      complete_run();
   end
endmodule : testbench
`default_nettype wire
